// [bmc_defs.svh]
// bmc_defs.svh: offsets, reset values and timing of the burst controller
// assumes: included by bare name; apb addresses are word aligned
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH
`define BMC_OFS_SETUP 12'h000
`define BMC_OFS_WIDTH 12'h004
`define BMC_OFS_DEST 12'h008
`define BMC_OFS_OWN 12'h00c
`define BMC_OFS_STAT 12'h010
`define BMC_PAGE_TXP 7'h01
`define BMC_PAGE_RXP 7'h02
`define BMC_RST_SETUP 14'h006c
`define BMC_RST_WIDTH 22'h202044
`define BMC_SETUP_AUTO 13
`define BMC_CLK_MHZ 250
`define BMC_BIT_RATE_KBPS 50
`define BMC_SETTLE_US 650
`define BMC_PREAMBLE_BITS 10
`define BMC_CRC_INIT 16'hffff
`define BMC_CRC_POLY 16'h1021
`endif

// [bmc_pkg.sv]
// bmc_pkg: state and phase types of the burst controller
// assumes: compiled before bmc_ctrl
package bmc_pkg;
  typedef enum logic [5:0] {
    st_off = 6'b000001, st_stby = 6'b000010, st_settle = 6'b000100,
    st_rx = 6'b001000, st_tx = 6'b010000, st_carr = 6'b100000
  } bmc_state_e;
  typedef enum logic [4:0] {
    tp_pre = 5'b00001, tp_adr = 5'b00010, tp_pay = 5'b00100,
    tp_crc = 5'b01000, tp_fin = 5'b10000
  } bmc_txph_e;
  typedef enum logic [2:0] {
    rp_hunt = 3'b001, rp_pay = 3'b010, rp_crc = 3'b100
  } bmc_rxph_e;
endpackage

// [bmc_ctrl.sv]
// bmc_ctrl: packet burst controller with apb registers
// assumes: mode pins and rx link are asynchronous, single pclk domain
// Behaviour
// RL1 - host loads address and payload first
// RL2 - both pins high: power up, frame, send
// RL3 - done flag rises when transmit ends
// RL4 - auto repeat resends while activate high
// RL5 - activate low: finish packet, then standby
// RL6 - select low: finish packet, then receive
// RL7 - started packet always completes before mode change
// RL8 - no repeat, held high: carrier follows
// RL9 - tx done clears on select or power low
// RL10 - receive listens 650 us after selection
// RL11 - carrier flag on detected carrier
// RL12 - address flag on own address match
// RL13 - good crc: store payload, raise done
// RL14 - host drops activate, then reads payload
// RL15 - last payload read clears done and address
// RL16 - select rising in receive starts transmit
// RL17 - pin change mid packet drops it
// RL18 - host should use long varied addresses
// RL19 - configuration kept in power down, standby
// RL20 - registers reachable in every mode
// RL21 - all registers read back
// RL22 - status shows done and address flags
// RL23 - power low: off; activate low: standby
// RL24 - carrier flag drops off carrier or receive
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "bmc_defs.svh"
module bmc_ctrl #(
  parameter int BIT_CYCLES = `BMC_CLK_MHZ * 1000 / `BMC_BIT_RATE_KBPS,
  parameter int SETTLE_CYCLES = `BMC_SETTLE_US * `BMC_CLK_MHZ
) (
  input wire logic pclk, // 250 MHz clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped address
  input wire logic power_on_control, // mode pin
  input wire logic radio_activate, // mode pin
  input wire logic transmit_select, // mode pin
  input wire logic carrier_in, // carrier seen by radio
  input wire logic rx_link_clk, // received bit clock
  input wire logic rx_data_in, // received bit
  output logic radio_power, // radio powered
  output logic tx_on, // transmitter on
  output logic tx_bit, // transmitted bit
  output logic rx_on, // receiver on
  output logic packet_done_flag, // data ready
  output logic address_hit_flag, // address match
  output logic carrier_sensed_flag // carrier detect
);
  bmc_pkg::bmc_state_e state_q, state_d, want;
  bmc_pkg::bmc_txph_e tph_q;
  bmc_pkg::bmc_rxph_e rph_q;
  logic [5:0] pin_raw, s1_q, s2_q, s3_q, st_q;
  logic pwr, act, txs, car, rxd, rx_tick;
  logic [13:0] setup_q;
  logic [21:0] width_q;
  logic [31:0] dest_q, own_q;
  logic [31:0] txp_q [8];
  logic [31:0] rxp_q [8];
  logic [31:0] rxs_q [8];
  logic [31:0] rd_d;
  logic err_d, wr_en, rd_en, rx_read_last;
  logic [2:0] rx_afw, tx_afw;
  logic [5:0] rx_pw, tx_pw;
  logic [12:0] div_q;
  logic bit_tick, tx_start, tx_end, cur_bit;
  logic [7:0] tcnt_q, rcnt_q;
  logic [15:0] tcrc_q, rcrc_q, rsum_q;
  logic [17:0] settle_q;
  logic [31:0] sr_q, sr_n, exp_a, mask_a;
  logic [5:0] seen_q;
  logic match, rx_good, rx_bad, rx_drop;
  logic done_q, from_tx_q, hit_q, cs_q, hit_set;

  // one step of the crc shift register, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `BMC_CRC_POLY : 16'h0000);
  endfunction

  // own address as it lands in the shift register, byte 0 oldest
  function automatic logic [31:0] addr_seq(input logic [31:0] a,
                                           input logic [2:0] n);
    addr_seq = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(n)) begin
        addr_seq[(int'(n) - 1 - i) * 8 +: 8] = a[i * 8 +: 8];
      end
    end
  endfunction

  // pins pass three flops; a change counts once stages two and three agree
  assign pin_raw = {rx_data_in, rx_link_clk, carrier_in,
                    transmit_select, radio_activate, power_on_control};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
      st_q <= 6'h00;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (s2_q & s3_q) | (st_q & (s2_q ^ s3_q));
    end
  end
  assign pwr = st_q[0];
  assign act = st_q[1];
  assign txs = st_q[2];
  assign car = st_q[3];
  assign rxd = st_q[5];
  // rising edge of the link clock once it is stable
  assign rx_tick = s2_q[4] & s3_q[4] & ~st_q[4];

  assign rx_afw = width_q[2:0];
  assign tx_afw = width_q[6:4];
  assign rx_pw = width_q[13:8];
  assign tx_pw = width_q[21:16];

  // apb: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite; // RL20
  assign rd_en = psel & ~penable & ~pwrite;
  always_comb begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == `BMC_OFS_SETUP) begin
      rd_d = {18'h00000, setup_q}; // RL21
    end else if (paddr == `BMC_OFS_WIDTH) begin
      rd_d = {10'h000, width_q};
    end else if (paddr == `BMC_OFS_DEST) begin
      rd_d = dest_q;
    end else if (paddr == `BMC_OFS_OWN) begin
      rd_d = own_q;
    end else if (paddr == `BMC_OFS_STAT) begin
      rd_d = {18'h00000, state_q, 5'h00, cs_q, hit_q, done_q}; // RL22
    end else if (paddr[11:5] == `BMC_PAGE_TXP && paddr[1:0] == 2'b00) begin
      rd_d = txp_q[paddr[4:2]];
    end else if (paddr[11:5] == `BMC_PAGE_RXP && paddr[1:0] == 2'b00) begin
      rd_d = rxp_q[paddr[4:2]];
    end else begin
      err_d = 1'b1;
    end
  end

  // read answer and error flag, both valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= rd_en ? rd_d : 32'h0000_0000;
      pslverr <= err_d;
    end
  end

  // configuration only sees presetn, so power down keeps it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_q <= `BMC_RST_SETUP;
      width_q <= `BMC_RST_WIDTH;
      dest_q <= 32'h0000_0000;
      own_q <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
        txp_q[i] <= 32'h0000_0000;
      end
    end else if (wr_en & ~err_d) begin
      if (paddr == `BMC_OFS_SETUP) begin
        setup_q <= pwdata[13:0]; // RL19
      end else if (paddr == `BMC_OFS_WIDTH) begin
        width_q <= pwdata[21:0];
      end else if (paddr == `BMC_OFS_DEST) begin
        dest_q <= pwdata;
      end else if (paddr == `BMC_OFS_OWN) begin
        own_q <= pwdata;
      end else if (paddr[11:5] == `BMC_PAGE_TXP) begin
        txp_q[paddr[4:2]] <= pwdata;
      end
    end
  end

  // reading the word holding the last payload byte ends the readout
  assign rx_read_last = psel & penable & ~pwrite &
                        paddr[11:5] == `BMC_PAGE_RXP &&
                        paddr[4:2] == 3'(rx_pw - 6'd1 >> 2);

  // mode asked for by the pins
  always_comb begin
    if (!pwr) begin
      want = bmc_pkg::st_off; // RL23
    end else if (!act) begin
      want = bmc_pkg::st_stby;
    end else if (txs) begin
      want = bmc_pkg::st_tx; // RL2
    end else begin
      want = bmc_pkg::st_settle;
    end
  end

  // mode machine; transmit only leaves at a packet end
  always_comb begin
    state_d = state_q;
    case (state_q)
      bmc_pkg::st_tx: begin
        if (tx_end) begin
          if (want != bmc_pkg::st_tx) begin
            state_d = want; // RL5 RL6
          end else if (setup_q[`BMC_SETUP_AUTO]) begin
            state_d = bmc_pkg::st_tx; // RL4
          end else begin
            state_d = bmc_pkg::st_carr; // RL8
          end
        end
      end
      bmc_pkg::st_rx: begin
        if (want != bmc_pkg::st_settle) begin
          state_d = want; // RL16 RL17
        end
      end
      bmc_pkg::st_settle: begin
        if (want != bmc_pkg::st_settle) begin
          state_d = want;
        end else if (settle_q == 18'(SETTLE_CYCLES - 1)) begin
          state_d = bmc_pkg::st_rx; // RL10
        end
      end
      bmc_pkg::st_carr: begin
        if (want != bmc_pkg::st_tx) begin
          state_d = want;
        end
      end
      default: begin
        state_d = want;
      end
    endcase
  end
  assign tx_start = state_d == bmc_pkg::st_tx &&
                    (state_q != bmc_pkg::st_tx || tx_end);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= bmc_pkg::st_off;
    end else begin
      state_q <= state_d;
    end
  end

  // settle timer runs only while waiting to listen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 18'h00000;
    end else if (state_q == bmc_pkg::st_settle) begin
      settle_q <= settle_q + 18'h00001;
    end else begin
      settle_q <= 18'h00000;
    end
  end

  // bit rate enable, restarted with each packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 13'h0000;
    end else if (tx_start || bit_tick) begin
      div_q <= 13'h0000;
    end else begin
      div_q <= div_q + 13'h0001;
    end
  end
  assign bit_tick = state_q == bmc_pkg::st_tx &&
                    div_q == 13'(BIT_CYCLES - 1);
  assign tx_end = bit_tick && tph_q == bmc_pkg::tp_fin; // RL7

  // bit on the air for the current phase and count
  always_comb begin
    case (tph_q)
      bmc_pkg::tp_pre: cur_bit = ~tcnt_q[0];
      bmc_pkg::tp_adr: cur_bit = dest_q[{tcnt_q[4:3], ~tcnt_q[2:0]}];
      bmc_pkg::tp_pay: cur_bit = txp_q[tcnt_q[7:5]][{tcnt_q[4:3], ~tcnt_q[2:0]}];
      bmc_pkg::tp_crc: cur_bit = tcrc_q[15];
      default: cur_bit = 1'b0;
    endcase
  end

  // framer: preamble, address, payload, crc over the payload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tph_q <= bmc_pkg::tp_pre;
      tcnt_q <= 8'h00;
      tcrc_q <= `BMC_CRC_INIT;
      tx_bit <= 1'b0;
    end else if (tx_start) begin
      tph_q <= bmc_pkg::tp_pre; // RL2
      tcnt_q <= 8'h00;
      tcrc_q <= `BMC_CRC_INIT;
    end else if (state_q == bmc_pkg::st_carr) begin
      tx_bit <= 1'b0; // RL8
    end else if (bit_tick) begin
      tx_bit <= cur_bit;
      tcnt_q <= tcnt_q + 8'h01;
      case (tph_q)
        bmc_pkg::tp_pre: begin
          if (tcnt_q == 8'(`BMC_PREAMBLE_BITS - 1)) begin
            tph_q <= bmc_pkg::tp_adr;
            tcnt_q <= 8'h00;
          end
        end
        bmc_pkg::tp_adr: begin
          if (tcnt_q[5:0] == 6'({tx_afw, 3'b000} - 6'd1)) begin
            tph_q <= bmc_pkg::tp_pay;
            tcnt_q <= 8'h00;
          end
        end
        bmc_pkg::tp_pay: begin
          tcrc_q <= crc_step(tcrc_q, cur_bit);
          if ({1'b0, tcnt_q} == 9'({tx_pw, 3'b000} - 9'd1)) begin
            tph_q <= bmc_pkg::tp_crc;
            tcnt_q <= 8'h00;
          end
        end
        bmc_pkg::tp_crc: begin
          tcrc_q <= {tcrc_q[14:0], 1'b0};
          if (tcnt_q == 8'h0f) begin
            tph_q <= bmc_pkg::tp_fin;
          end
        end
        default: begin
          tph_q <= bmc_pkg::tp_fin;
        end
      endcase
    end
  end

  // address hunt compares the newest bits with the own address
  assign sr_n = {sr_q[30:0], rxd};
  assign exp_a = addr_seq(own_q, rx_afw);
  assign mask_a = ~(32'hffff_ffff << {rx_afw, 3'b000});
  assign match = rph_q == bmc_pkg::rp_hunt && rx_tick &&
                 state_q == bmc_pkg::st_rx && state_d == bmc_pkg::st_rx &&
                 {1'b0, seen_q} + 7'd1 >= {1'b0, rx_afw, 3'b000} &&
                 ((sr_n ^ exp_a) & mask_a) == 32'h0000_0000;
  assign rx_good = rph_q == bmc_pkg::rp_crc && rx_tick &&
                   state_q == bmc_pkg::st_rx && rcnt_q == 8'h0f &&
                   state_d == bmc_pkg::st_rx &&
                   {rsum_q[14:0], rxd} == rcrc_q;
  assign rx_bad = rph_q == bmc_pkg::rp_crc && rx_tick &&
                  state_q == bmc_pkg::st_rx && rcnt_q == 8'h0f && !rx_good;
  assign rx_drop = state_q == bmc_pkg::st_rx &&
                   state_d != bmc_pkg::st_rx && rph_q != bmc_pkg::rp_hunt;

  // deframer; any exit from receive throws the packet away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rph_q <= bmc_pkg::rp_hunt;
      rcnt_q <= 8'h00;
      rcrc_q <= `BMC_CRC_INIT;
      rsum_q <= 16'h0000;
      sr_q <= 32'h0000_0000;
      seen_q <= 6'h00;
    end else if (state_q != bmc_pkg::st_rx ||
                 state_d != bmc_pkg::st_rx) begin
      // the leaving edge already resets, so no half packet survives
      rph_q <= bmc_pkg::rp_hunt; // RL17
      seen_q <= 6'h00;
    end else if (rx_tick) begin
      rcnt_q <= rcnt_q + 8'h01;
      case (rph_q)
        bmc_pkg::rp_hunt: begin
          sr_q <= sr_n;
          seen_q <= (seen_q == 6'h20) ? seen_q : seen_q + 6'h01;
          if (match) begin
            rph_q <= bmc_pkg::rp_pay;
            rcnt_q <= 8'h00;
            rcrc_q <= `BMC_CRC_INIT;
          end
        end
        bmc_pkg::rp_pay: begin
          rcrc_q <= crc_step(rcrc_q, rxd);
          if ({1'b0, rcnt_q} == 9'({rx_pw, 3'b000} - 9'd1)) begin
            rph_q <= bmc_pkg::rp_crc;
            rcnt_q <= 8'h00;
          end
        end
        default: begin
          rsum_q <= {rsum_q[14:0], rxd};
          if (rcnt_q == 8'h0f) begin
            rph_q <= bmc_pkg::rp_hunt;
            seen_q <= 6'h00;
          end
        end
      endcase
    end
  end

  // payload shadow; visible to software only after a good crc
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        rxs_q[i] <= 32'h0000_0000;
        rxp_q[i] <= 32'h0000_0000;
      end
    end else if (rx_good) begin
      for (int i = 0; i < 8; i++) begin
        rxp_q[i] <= rxs_q[i]; // RL13
      end
    end else if (rx_tick && rph_q == bmc_pkg::rp_pay &&
                 state_q == bmc_pkg::st_rx) begin
      rxs_q[rcnt_q[7:5]][{rcnt_q[4:3], ~rcnt_q[2:0]}] <= rxd;
    end
  end

  // flags: a set always beats a clear in the same cycle
  assign hit_set = match;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      from_tx_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      if (tx_end || rx_good) begin
        done_q <= 1'b1; // RL3 RL13
        from_tx_q <= tx_end;
      end else if ((from_tx_q && (!txs || !pwr)) || // RL9
                   (!from_tx_q && rx_read_last)) begin
        done_q <= 1'b0; // RL15
      end
      if (hit_set) begin
        hit_q <= 1'b1; // RL12
      end else if (rx_read_last || rx_bad || rx_drop) begin
        hit_q <= 1'b0; // RL15
      end
    end
  end

  // carrier flag only while listening
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= 1'b0;
    end else begin
      cs_q <= state_q == bmc_pkg::st_rx && car; // RL11 RL24
    end
  end

  // radio controls follow the mode directly from the state flops
  assign radio_power = state_q[2] | state_q[3] | state_q[4] | state_q[5];
  assign tx_on = state_q[4] | state_q[5];
  assign rx_on = state_q[2] | state_q[3];
  assign packet_done_flag = done_q;
  assign address_hit_flag = hit_q;
  assign carrier_sensed_flag = cs_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_done_tx;
    tx_end |=> packet_done_flag;
  endproperty
  a_done_tx: assert property (p_done_tx) // RL3
    else $error("done flag missing after transmit");
  property p_repeat;
    tx_end && want == bmc_pkg::st_tx && setup_q[`BMC_SETUP_AUTO]
      |=> state_q == bmc_pkg::st_tx && tph_q == bmc_pkg::tp_pre;
  endproperty
  a_repeat: assert property (p_repeat) // RL4
    else $error("auto repeat did not restart");
  property p_stby;
    tx_end && want == bmc_pkg::st_stby |=> state_q == bmc_pkg::st_stby;
  endproperty
  a_stby: assert property (p_stby) // RL5
    else $error("no standby after packet");
  property p_run;
    state_q == bmc_pkg::st_tx && !tx_end |=> state_q == bmc_pkg::st_tx;
  endproperty
  a_run: assert property (p_run) // RL7
    else $error("transmit left early");
  property p_carr;
    tx_end && want == bmc_pkg::st_tx && !setup_q[`BMC_SETUP_AUTO]
      |=> state_q == bmc_pkg::st_carr && tx_on ##1 !tx_bit;
  endproperty
  a_carr: assert property (p_carr) // RL8
    else $error("carrier not kept");
  property p_settle;
    state_q == bmc_pkg::st_settle && state_d == bmc_pkg::st_rx
      |-> settle_q == 18'(SETTLE_CYCLES - 1);
  endproperty
  a_settle: assert property (p_settle) // RL10
    else $error("listen started at wrong time");
  property p_drop;
    state_q == bmc_pkg::st_rx && want != bmc_pkg::st_settle
      |=> state_q != bmc_pkg::st_rx && rph_q == bmc_pkg::rp_hunt;
  endproperty
  a_drop: assert property (p_drop) // RL17
    else $error("receive kept after pin change");
  property p_cs;
    carrier_sensed_flag |-> $past(state_q) == bmc_pkg::st_rx;
  endproperty
  a_cs: assert property (p_cs) // RL24
    else $error("carrier flag outside receive");
  property p_clr;
    rx_read_last && !from_tx_q && !rx_good && !hit_set
      |=> !packet_done_flag && !address_hit_flag;
  endproperty
  a_clr: assert property (p_clr) // RL15
    else $error("flags not cleared by readout");
  c_repeat: cover property (tx_end ##1 state_q == bmc_pkg::st_tx);
  c_rx_good: cover property (rx_good ##1 packet_done_flag);
  c_carr: cover property (state_q == bmc_pkg::st_carr);
endmodule
`default_nettype wire

// [bmc_air_model.sv]
// bmc_air_model: far radio that sends one frame to the receiver
// assumes: bench pulses send with frame and nbits already stable
`timescale 1ns/1ns
`default_nettype none
module bmc_air_model (
  input wire logic send, // start a frame
  input wire logic [63:0] frame, // bits, last one at index 0
  input wire logic [6:0] nbits, // bits in the frame
  output logic link_clk, // bit clock, still between frames
  output logic link_data, // bit, changes on falling edge
  output logic carrier, // carrier on air
  output logic busy // frame in flight
);
  // all lines idle low until the first frame
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
    carrier = 1'b0;
    busy = 1'b0;
  end
  // 48 ns bit clock; data inverts after the frame so no stale bit looks valid
  always @(posedge send) begin
    busy = 1'b1;
    carrier = 1'b1;
    for (int i = 0; i < 64; i++) begin
      if (i < nbits) begin
        link_data = frame[nbits - 7'd1 - 7'(i)];
        #24 link_clk = 1'b1;
        #24 link_clk = 1'b0;
      end
    end
    link_data = ~link_data;
    carrier = 1'b0;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// [bmc_ctrl_tb_top.sv]
// bmc_ctrl_tb_top: self-checking bench of the burst controller
// assumes: bmc_pkg, bmc_ctrl and bmc_air_model compiled first
`timescale 1ns/1ns
`default_nettype none
`include "bmc_defs.svh"
module bmc_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic power_on_control, radio_activate, transmit_select, carrier_in;
  logic rx_link_clk, rx_data_in, radio_power, tx_on, tx_bit, rx_on;
  logic packet_done_flag, address_hit_flag, carrier_sensed_flag;
  logic send, busy;
  logic [63:0] frame;
  logic [6:0] nbits;
  int err_count, compares, cyc;
  // short counts keep the run brief
  bmc_ctrl #(.BIT_CYCLES(8), .SETTLE_CYCLES(20)) dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .power_on_control, .radio_activate, .transmit_select,
    .carrier_in, .rx_link_clk, .rx_data_in, .radio_power, .tx_on, .tx_bit,
    .rx_on, .packet_done_flag, .address_hit_flag, .carrier_sensed_flag);
  bmc_air_model air (.send, .frame, .nbits, .link_clk(rx_link_clk),
    .link_data(rx_data_in), .carrier(carrier_in), .busy);
  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string m);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("Error %0t %s seen %h expected %h", $time, m, s, e);
    end
  endtask
  // one apb transfer; waits for pready, data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no own limit: only the hang guard ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e, "register read");
  endtask
  task automatic pins(input logic p, input logic a, input logic t);
    @(posedge pclk);
    power_on_control <= p;
    radio_activate <= a;
    transmit_select <= t;
  endtask
  task automatic wait_tx(input logic v);
    do begin
      @(negedge pclk);
    end while (tx_on !== v);
  endtask
  // ccitt crc over one payload byte, msb first
  function automatic logic [15:0] crc8(input logic [7:0] b);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  // frame: filler, 24 bit own address, payload 9c, crc (x flips bits)
  task automatic send_frame(input logic [15:0] x);
    @(posedge pclk);
    frame <= {8'h00, 8'h55, 24'he9a3c5, 8'h9c, crc8(8'h9c) ^ x};
    nbits <= 7'd56;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
  endtask
  task automatic wait_air();
    while (busy === 1'b1) @(negedge pclk);
    repeat (6) @(negedge pclk);
  endtask
  task automatic t_regs();
    rchk(`BMC_OFS_SETUP, 32'hffffffff, 32'h6c);
    rchk(`BMC_OFS_WIDTH, 32'hffffffff, 32'h202044);
    rchk(`BMC_OFS_STAT, 32'h3f07, 32'h0100);
    apb(1'b0, 12'h080, 32'h0);
    chk(err, 1'b1, "unmapped error");
    apb(1'b1, `BMC_OFS_WIDTH, 32'h00010113);
    apb(1'b1, `BMC_OFS_DEST, 32'hb5);
    apb(1'b1, `BMC_OFS_OWN, 32'hc5a3e9);
    apb(1'b1, 12'h020, 32'h3c);
    rchk(`BMC_OFS_OWN, 32'hffffffff, 32'hc5a3e9);
  endtask
  // short burst, then carrier, then hand over to receive
  task automatic t_tx();
    logic [41:0] e;
    e = {10'b1010101010, 8'hb5, 8'h3c, crc8(8'h3c)};
    pins(1'b1, 1'b1, 1'b1);
    wait_tx(1'b1);
    chk(radio_power, 1'b1, "radio power");
    repeat (12) @(negedge pclk);
    for (int i = 41; i >= 0; i--) begin
      chk(tx_bit, e[i], "tx bit");
      if (i > 0) repeat (8) @(negedge pclk);
    end
    repeat (8) @(negedge pclk);
    chk(packet_done_flag, 1'b1, "tx done");
    chk({tx_on, tx_bit}, 2'b10, "carrier");
    rchk(`BMC_OFS_STAT, 32'h3f07, 32'h2001);
    pins(1'b1, 1'b1, 1'b0);
    repeat (6) @(negedge pclk);
    chk(packet_done_flag, 1'b0, "done clear");
    chk(rx_on, 1'b1, "rx on");
    rchk(`BMC_OFS_STAT, 32'h3f00, 32'h0400);
    repeat (25) @(negedge pclk);
    rchk(`BMC_OFS_STAT, 32'h3f00, 32'h0800);
  endtask
  task automatic t_rx();
    send_frame(16'h0);
    repeat (20) @(negedge pclk);
    chk(carrier_sensed_flag, 1'b1, "carrier flag");
    repeat (380) @(negedge pclk);
    chk({address_hit_flag, packet_done_flag}, 2'b10, "hit");
    wait_air();
    chk(packet_done_flag, 1'b1, "rx done");
    chk(carrier_sensed_flag, 1'b0, "carrier gone");
    pins(1'b1, 1'b0, 1'b0);
    repeat (6) @(negedge pclk);
    rchk(`BMC_OFS_STAT, 32'h3f07, 32'h0203);
    rchk(12'h040, 32'hff, 32'h9c);
    repeat (2) @(negedge pclk);
    chk({address_hit_flag, packet_done_flag}, 2'b00, "read clear");
  endtask
  // bad crc, then a good frame cut short by a pin change
  task automatic t_bad();
    pins(1'b1, 1'b1, 1'b0);
    repeat (30) @(negedge pclk);
    send_frame(16'h0001);
    wait_air();
    chk({address_hit_flag, packet_done_flag}, 2'b00, "bad crc");
    send_frame(16'h0);
    repeat (400) @(negedge pclk);
    pins(1'b1, 1'b0, 1'b0);
    repeat (8) @(negedge pclk);
    chk(address_hit_flag, 1'b0, "dropped hit");
    wait_air();
    chk(packet_done_flag, 1'b0, "dropped done");
  endtask
  // repeat mode; pin changes wait for the packet end
  task automatic t_rep();
    apb(1'b1, `BMC_OFS_SETUP, 32'h206c);
    pins(1'b1, 1'b1, 1'b0);
    repeat (30) @(negedge pclk);
    rchk(`BMC_OFS_STAT, 32'h3f00, 32'h0800);
    pins(1'b1, 1'b1, 1'b1);
    repeat (8) @(negedge pclk);
    chk(tx_on, 1'b1, "rx to tx");
    repeat (400) @(negedge pclk);
    rchk(`BMC_OFS_STAT, 32'h3f01, 32'h1001);
    pins(1'b1, 1'b0, 1'b1);
    repeat (10) @(negedge pclk);
    rchk(`BMC_OFS_STAT, 32'h3f00, 32'h1000);
    wait_tx(1'b0);
    rchk(`BMC_OFS_STAT, 32'h3f00, 32'h0200);
    pins(1'b0, 1'b0, 1'b1);
    repeat (8) @(negedge pclk);
    chk(packet_done_flag, 1'b0, "power clear");
    rchk(`BMC_OFS_STAT, 32'h3f00, 32'h0100);
    rchk(`BMC_OFS_SETUP, 32'hffffffff, 32'h206c);
    rchk(`BMC_OFS_DEST, 32'hffffffff, 32'hb5);
  endtask
  // reset for four cycles, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    power_on_control = 1'b0;
    radio_activate = 1'b0;
    transmit_select = 1'b0;
    send = 1'b0;
    frame = 64'h0;
    nbits = 7'h00;
    err_count = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_bad();
    t_rep();
    print_verdict();
  end
endmodule
`default_nettype wire
